// ==== design/cbfs_params.svh ====
// Constants for the CAN bus fault supervisor
`ifndef CBFS_PARAMS_SVH
`define CBFS_PARAMS_SVH
`define CBFS_CLK_MHZ        50
`define CBFS_QUAL_CYCLES    5
`define CBFS_TXDOM_US       300
`define CBFS_TXDOM_CYC      (`CBFS_TXDOM_US * `CBFS_CLK_MHZ)
`define CBFS_CLAMP_US       300
`define CBFS_CLAMP_CYC      (`CBFS_CLAMP_US * `CBFS_CLK_MHZ)
`define CBFS_PAT_NONE       3'h0
`endif

// ==== design/cbfs_pkg.sv ====
// Types for the CAN bus fault supervisor
package cbfs_pkg;
    // Bus short diagnosis codes
    typedef enum logic [2:0] {
        CBFS_F_NONE   = 3'b000,
        CBFS_F_GND    = 3'b001,
        CBFS_F_VBAT   = 3'b010,
        CBFS_F_CANL_G = 3'b011,
        CBFS_F_CANH_G = 3'b100,
        CBFS_F_CANL_B = 3'b101,
        CBFS_F_CANH_B = 3'b110,
        CBFS_F_UNK    = 3'b111
    } cbfs_fault_e;
endpackage

// ==== design/cbfs_sync.sv ====
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module cbfs_sync #(
    parameter int W = 1
) (
    input  wire logic         i_ref_clk, // Clock
    input  wire logic         i_rst_b,   // Sync reset, active low
    input  wire logic [W-1:0] i_async,   // Pin levels
    output logic      [W-1:0] o_sync     // Synchronised levels
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule

// ==== design/cbfs_top.sv ====
// CAN bus fault supervisor: short, clamp, TXD and RXD pin faults
`timescale 1ns/100ps
`include "cbfs_params.svh"
module cbfs_top
    import cbfs_pkg::*;
#(
    parameter int TXDOM_CYC = `CBFS_TXDOM_CYC,
    parameter int CLAMP_CYC = `CBFS_CLAMP_CYC,
    parameter int QUAL_N    = `CBFS_QUAL_CYCLES
) (
    input  wire logic        i_ref_clk,     // 50 MHz clock
    input  wire logic        i_rst_b,       // Sync reset, active low
    input  wire logic        i_txd,         // TXD pin, low is dominant
    input  wire logic        i_rxd_pin,     // Sensed RXD pin level
    input  wire logic        i_rx_diff,     // Receiver, 1 is dominant
    input  wire logic [5:0]  i_cmp,         // Lg Hg Lb Hb L5 H5
    input  wire logic        i_transmit_receive_mode_mode,   // transmit_receive_mode set
    input  wire logic        i_normal_entry,// Pulse: normal mode entered
    input  wire logic        i_flag_read,   // Pulse: flags read out
    output logic             o_drv_dom,     // Drive bus dominant
    output logic             o_drv_en,      // Bus driver enabled
    output logic             o_rxd,         // RXD data out
    output logic             o_rxd_oe,      // RXD driver enable
    output logic             o_bus_fail,    // Bus failure flag
    output cbfs_fault_e      o_bus_fault,   // Qualified short code
    output logic             o_clamp_flag,  // Dominant clamp flag
    output logic             o_txdom_flag,  // TXD permanent dominant flag
    output logic             o_rxrec_flag   // RXD permanent recessive flag
);
    import cbfs_pkg::*;

    logic [9:0] s;
    cbfs_sync #(.W(10)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_async   ({i_txd, i_rxd_pin, i_rx_diff, i_cmp, i_transmit_receive_mode_mode}),
        .o_sync    (s)
    );
    logic txd_s, rxdp_s, dif_s, mode_s;
    logic [5:0] cmp_s;
    assign {txd_s, rxdp_s, dif_s, cmp_s, mode_s} = s;

    function automatic cbfs_fault_e rec_decode(input logic [5:0] c);
        if (c[5:4] == 2'b00)
            return CBFS_F_GND;
        else if (c[3:2] == 2'b11 || c[1:0] == 2'b11)
            return CBFS_F_VBAT;
        else
            return CBFS_F_NONE;
    endfunction

    function automatic cbfs_fault_e dom_decode(input logic [5:0] c);
        if (c[4] == 1'b0)
            return CBFS_F_CANH_G;
        else if (c[3] || c[1])
            return CBFS_F_CANL_B;
        else if (c[2] || c[0])
            return CBFS_F_CANH_B;
        else
            return CBFS_F_NONE;
    endfunction

    logic        dif_d_ff;
    logic        txd_d_ff;
    logic        rxd_int_d_ff;
    logic        drv_off_ff;
    logic        txdom_ff, rxrec_ff, clamp_ff, bfail_ff;
    logic        rearm_ff;
    logic [31:0] txcnt_ff, clcnt_ff;
    logic [2:0]  qcnt_ff;
    cbfs_fault_e rec_ff, cur_ff, last_ff, qual_ff;
    logic        rxd_ff;

    wire rx_rise = dif_d_ff && !dif_s;        // Bus back to recessive
    wire rx_fall = !dif_d_ff && dif_s;
    wire cycle_end = rx_fall;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            dif_d_ff <= 1'b0;
            txd_d_ff <= 1'b0;     // Same as sync reset: no false edge
            rxd_int_d_ff <= 1'b0;
        end else begin
            dif_d_ff <= dif_s;
            txd_d_ff <= txd_s;
            rxd_int_d_ff <= !dif_s;
        end
    end

    // Recessive sample detects, dominant sample names the line
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            rec_ff <= CBFS_F_NONE;
            cur_ff <= CBFS_F_NONE;
        end else begin
            if (!dif_s && txd_s)
                rec_ff <= rec_decode(cmp_s);
            if (dif_s && !txd_s)
                cur_ff <= (rec_ff == CBFS_F_NONE) ? CBFS_F_NONE
                          : (dom_decode(cmp_s) == CBFS_F_NONE
                             ? CBFS_F_CANL_G : dom_decode(cmp_s));
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            qcnt_ff <= 3'h0;
            last_ff <= CBFS_F_NONE;
            qual_ff <= CBFS_F_NONE;
            bfail_ff <= 1'b0;
        end else if (cycle_end) begin
            last_ff <= cur_ff;
            if (cur_ff == CBFS_F_NONE || cur_ff != last_ff)
                qcnt_ff <= (cur_ff == CBFS_F_NONE) ? 3'h0 : 3'h1;
            else if (qcnt_ff < 3'(QUAL_N))
                qcnt_ff <= qcnt_ff + 3'h1;
            if (cur_ff != CBFS_F_NONE && cur_ff == last_ff
                && qcnt_ff + 3'h1 >= 3'(QUAL_N)) begin
                bfail_ff <= 1'b1;
                qual_ff  <= cur_ff;
            end else if (i_flag_read) begin
                bfail_ff <= 1'b0;
            end
        end else if (i_flag_read) begin
            bfail_ff <= 1'b0;
        end
    end

    // Bus clamp: dominant receiver for CLAMP_CYC cycles, whatever TXD drives
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            clcnt_ff <= '0;
            clamp_ff <= 1'b0;
        end else begin
            clcnt_ff <= dif_s ? ((clcnt_ff < 32'(CLAMP_CYC))
                        ? clcnt_ff + 32'h1 : clcnt_ff) : 32'h0;
            if (dif_s && clcnt_ff >= 32'(CLAMP_CYC))
                clamp_ff <= 1'b1;
            else if (i_flag_read)
                clamp_ff <= 1'b0;
        end
    end

    // TXD permanent dominant, also covers TXD-RXD short
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            txcnt_ff <= '0;
            txdom_ff <= 1'b0;
        end else begin
            txcnt_ff <= !txd_s ? ((txcnt_ff < 32'(TXDOM_CYC))
                        ? txcnt_ff + 32'h1 : txcnt_ff) : 32'h0;
            if (!txd_s && txcnt_ff >= 32'(TXDOM_CYC))
                txdom_ff <= 1'b1;
            else if (i_flag_read && txd_s)
                txdom_ff <= 1'b0;
        end
    end

    // RXD stuck recessive, checked each time the bus returns to recessive (rx_rise)
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            rxrec_ff <= 1'b0;
        end else if (rx_rise && rxdp_s && !rxd_int_d_ff) begin
            rxrec_ff <= 1'b1;
        end else if (!txd_s && txd_d_ff) begin
            rxrec_ff <= 1'b0;
        end
    end

    // Driver lockout; rearm needs recovery event, and re-enable needs mode set (before or after)
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            drv_off_ff <= 1'b1;
            rearm_ff   <= 1'b1;
        end else if (!txd_s && txcnt_ff >= 32'(TXDOM_CYC)) begin
            drv_off_ff <= 1'b1;
            rearm_ff   <= 1'b0;
        end else if (drv_off_ff) begin
            // Only a timeout lockout waits for a recovery event
            if (i_normal_entry || (txd_s && rx_fall))
                rearm_ff <= 1'b1;
            if (rearm_ff && !txdom_ff && !rxrec_ff && mode_s && txd_s)
                drv_off_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b)
            rxd_ff <= 1'b1;
        else
            rxd_ff <= !dif_s;
    end

    assign o_drv_en     = !drv_off_ff && mode_s;
    assign o_drv_dom    = o_drv_en && !txd_s;
    assign o_rxd        = rxd_ff;
    assign o_rxd_oe     = !rxrec_ff;
    assign o_bus_fail   = bfail_ff || clamp_ff;
    assign o_bus_fault  = qual_ff;
    assign o_clamp_flag = clamp_ff;
    assign o_txdom_flag = txdom_ff;
    assign o_rxrec_flag = rxrec_ff;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    drv_off_txdom_a: assert property (txdom_ff |-> !o_drv_dom)
        else $error("driver active with TXD dominant fault");
    rxd_release_a: assert property (rxrec_ff |-> !o_rxd_oe)
        else $error("RXD driven while stuck fault set");
    rxrec_set_a: assert property (
        rx_rise && rxdp_s && !rxd_int_d_ff |=> rxrec_ff)
        else $error("RXD stuck not detected");
    rxrec_clr_a: assert property (
        rxrec_ff && !txd_s && txd_d_ff && !rx_rise |=> !rxrec_ff)
        else $error("RXD fault not recovered");
    txdom_set_a: assert property (
        !txd_s && txcnt_ff >= 32'(TXDOM_CYC) |=> txdom_ff && drv_off_ff)
        else $error("TXD timeout not flagged");
    clamp_set_a: assert property (
        dif_s && clcnt_ff >= 32'(CLAMP_CYC) |=> clamp_ff)
        else $error("clamp not flagged");
    bfail_qual_a: assert property (
        $rose(bfail_ff) |-> $past(qcnt_ff) >= 3'(QUAL_N - 1))
        else $error("bus fault reported early");
    no_drive_flag_a: assert property (
        (txdom_ff || rxrec_ff) |-> !$fell(drv_off_ff))
        else $error("driver enabled with flag pending");
    dom_follow_a: assert property (
        o_drv_en |-> o_drv_dom == !$past(i_txd, 2))
        else $error("driver does not follow TXD");

    txdom_c: cover property ($rose(txdom_ff));
    rxrec_c: cover property ($rose(rxrec_ff));
    bfail_c: cover property ($rose(bfail_ff));
    reen_c:  cover property ($fell(drv_off_ff));
endmodule

// ==== test/cbfs_bus_model.sv ====
// Bus, comparator and RXD pin model facing the fault supervisor
`timescale 1ns/100ps
module cbfs_bus_model (
    input  wire logic       i_ref_clk, // Clock
    input  wire logic       i_drv_en,  // Driver enabled
    input  wire logic       i_drv_dom, // Driver dominant
    input  wire logic       i_rxd,     // RXD data
    input  wire logic       i_rxd_oe,  // RXD driver enable
    input  wire logic [1:0] i_short,   // 0 none, 1/2 L/H gnd, 3 H bat
    input  wire logic       i_clamp,   // Bus held dominant
    input  wire logic       i_stuck,   // RXD pin shorted high
    output logic            o_rx_diff, // Receiver, 1 is dominant
    output logic [5:0]      o_cmp,     // Lg Hg Lb Hb L5 H5
    output logic            o_rxd_pin  // Sensed RXD pin level
);
    logic last_ff = 1'b1;
    logic dom;
    always_ff @(posedge i_ref_clk) begin
        if (i_rxd_oe) begin
            last_ff <= i_rxd;
        end
    end
    assign dom = i_drv_en & i_drv_dom;
    // Receiver follows the driver so every short still gives bus cycles
    assign o_rx_diff = i_clamp | dom;
    assign o_cmp = dom ? ((i_short == 2'h3) ? 6'h15
                        : (i_short == 2'h2) ? 6'h00 : 6'h10)
                       : ((i_short == 2'h3) ? 6'h3F
                        : (i_short != 2'h0) ? 6'h00 : 6'h30);
    // Released pin has no pull: show the inverse of the last level
    assign o_rxd_pin = i_stuck ? 1'b1 : (i_rxd_oe ? i_rxd : ~last_ff);
endmodule

// ==== test/cbfs_top_tb.sv ====
// Self-checking bench for the CAN bus fault supervisor
`timescale 1ns/100ps
module cbfs_top_tb;
    import cbfs_pkg::*;
    logic        clk, rst_b, txd, rx_diff, rxd_pin, mode, nentry, fread;
    logic [5:0]  cmp;
    logic        drv_dom, drv_en, rxd, rxd_oe, bus_fail;
    logic        clamp_f, txdom_f, rxrec_f, clamp, stuck;
    logic [1:0]  short_sel;
    cbfs_fault_e bus_fault;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    cbfs_top #(.TXDOM_CYC(20), .CLAMP_CYC(20), .QUAL_N(5)) dut_u (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_txd(txd),
        .i_rxd_pin(rxd_pin), .i_rx_diff(rx_diff), .i_cmp(cmp),
        .i_transmit_receive_mode_mode(mode), .i_normal_entry(nentry), .i_flag_read(fread),
        .o_drv_dom(drv_dom), .o_drv_en(drv_en), .o_rxd(rxd),
        .o_rxd_oe(rxd_oe), .o_bus_fail(bus_fail), .o_bus_fault(bus_fault),
        .o_clamp_flag(clamp_f), .o_txdom_flag(txdom_f),
        .o_rxrec_flag(rxrec_f));
    cbfs_bus_model bus_u (
        .i_ref_clk(clk), .i_drv_en(drv_en), .i_drv_dom(drv_dom),
        .i_rxd(rxd), .i_rxd_oe(rxd_oe), .i_short(short_sel),
        .i_clamp(clamp), .i_stuck(stuck), .o_rx_diff(rx_diff),
        .o_cmp(cmp), .o_rxd_pin(rxd_pin));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string what, input logic [3:0] exp,
                       input logic [3:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic bus_cyc(input int n);
        repeat (n) begin
            txd = 1'b0;
            tick(6);
            txd = 1'b1;
            tick(6);
        end
    endtask
    task automatic start();
        {rst_b, mode, nentry, fread, clamp, stuck} = 6'h00;
        txd = 1'b1;
        short_sel = 2'h0;
        tick(5);
        chk("reset outputs", 4'h3,
            {drv_en, txdom_f | clamp_f | rxrec_f, rxd, rxd_oe});
        rst_b = 1'b1;
        mode = 1'b1;
        tick(6);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            $display("MISMATCH timeout expected 0 seen 1");
            conclude();
        end
    end

    initial begin
        start();
        chk("drv_en", 4'h1, {3'h0, drv_en});
        chk("drv_dom rec", 4'h0, {3'h0, drv_dom});
        txd = 1'b0;
        tick(4);
        chk("drv_dom dom", 4'h1, {3'h0, drv_dom});
        tick(4);
        chk("rxd dom", 4'h0, {3'h0, rxd});
        $display("test driver done");
        start();
        short_sel = 2'h1;
        bus_cyc(4);
        chk("fault early", {1'b0, CBFS_F_NONE}, {1'b0, bus_fault});
        bus_cyc(3);
        chk("fault canl", {1'b0, CBFS_F_CANL_G}, {1'b0, bus_fault});
        chk("bus_fail", 4'h1, {3'h0, bus_fail});
        start();
        short_sel = 2'h1;
        bus_cyc(3);
        short_sel = 2'h2;
        bus_cyc(4);
        chk("fault reset", {1'b0, CBFS_F_NONE}, {1'b0, bus_fault});
        bus_cyc(3);
        chk("fault canh", {1'b0, CBFS_F_CANH_G}, {1'b0, bus_fault});
        start();
        short_sel = 2'h3;
        bus_cyc(7);
        chk("fault vbat", {1'b0, CBFS_F_CANH_B}, {1'b0, bus_fault});
        $display("test short done");
        start();
        clamp = 1'b1;
        tick(12);
        chk("clamp early", 4'h0, {3'h0, clamp_f});
        tick(16);
        chk("clamp flag", 4'h3, {2'h0, clamp_f, bus_fail});
        $display("test clamp done");
        start();
        txd = 1'b0;
        tick(12);
        chk("txdom early", 4'h0, {3'h0, txdom_f});
        tick(16);
        chk("txdom on", 4'h2, {2'h0, txdom_f, drv_en});
        txd = 1'b1;
        mode = 1'b0;
        tick(4);
        chk("unread off", 4'h0, {3'h0, drv_en});
        pulse(fread);
        tick(4);
        chk("read mode low", 4'h0, {2'h0, txdom_f, drv_en});
        mode = 1'b1;
        tick(6);
        chk("no rearm", 4'h0, {3'h0, drv_en});
        pulse(nentry);
        tick(6);
        chk("reenabled", 4'h1, {3'h0, drv_en});
        txd = 1'b0;
        tick(28);
        chk("transmit_receive_mode short", 4'h2, {2'h0, txdom_f, drv_en});
        txd = 1'b1;
        tick(4);
        pulse(fread);
        tick(4);
        chk("rx edge off", 4'h0, {3'h0, drv_en});
        clamp = 1'b1;
        tick(6);
        chk("rx edge on", 4'h1, {3'h0, drv_en});
        $display("test txd dominant done");
        start();
        stuck = 1'b1;
        bus_cyc(1);
        chk("rxrec on", 4'h2, {2'h0, rxrec_f, rxd_oe});
        stuck = 1'b0;
        txd = 1'b0;
        tick(6);
        chk("rxrec off", 4'h1, {2'h0, rxrec_f, rxd_oe});
        $display("test rxd stuck done");
        conclude();
    end
endmodule
